// ==== verilog/charge_seq_pkg.sv ====
package charge_seq_pkg;

	// ---------------------------------------------------------------
	// Clock and time base
	// ---------------------------------------------------------------
	localparam int SYS_CLK_HZ   = 200_000_000;
	localparam int TICK_MS      = 500;
	localparam int TICK_CYCLES  = SYS_CLK_HZ / 1000 * TICK_MS;
	localparam int TICKS_PER_S  = 1000 / TICK_MS;

	// ---------------------------------------------------------------
	// Stage durations, in their own units, then in half-second ticks
	// ---------------------------------------------------------------
	localparam int SOFT_START_S      = 120;
	localparam int TOP_CHARGE_MIN    = 120;
	localparam int FAST_LIMIT_MIN    = 144;
	localparam int COLD_SAMPLE_S     = 1;
	localparam int SOFT_START_TICKS  = SOFT_START_S * TICKS_PER_S;
	localparam int TOP_CHARGE_TICKS  = TOP_CHARGE_MIN * 60 * TICKS_PER_S;
	localparam int FAST_LIMIT_TICKS  = FAST_LIMIT_MIN * 60 * TICKS_PER_S;
	localparam int COLD_SAMPLE_TICKS = COLD_SAMPLE_S * TICKS_PER_S;
	localparam int CNT_W             = 15;

	// ---------------------------------------------------------------
	// Current command levels, units of C/80
	// ---------------------------------------------------------------
	localparam int                 LEVEL_W     = 8;
	localparam logic [LEVEL_W-1:0] LEVEL_OFF   = 8'h00;
	localparam logic [LEVEL_W-1:0] LEVEL_FAST  = 8'h28;
	localparam logic [LEVEL_W-1:0] LEVEL_TOP   = 8'h08;
	localparam logic [LEVEL_W-1:0] LEVEL_MAINT = 8'h02;
	localparam int RAMP_STEP_TICKS = SOFT_START_TICKS / 40;

	// ---------------------------------------------------------------
	// Pulse pattern: forward, rest, reverse, rest
	// ---------------------------------------------------------------
	localparam int PULSE_W            = 10;
	localparam int PULSE_PERIOD_CYCLES = 1000;
	localparam int FWD_END_CYCLES     = 900;
	localparam int REV_START_CYCLES   = 920;
	localparam int REV_END_CYCLES     = 980;

	// ---------------------------------------------------------------
	// Sensor flag positions
	// ---------------------------------------------------------------
	localparam int FLAG_W       = 5;
	localparam int FLAG_PRESENT = 0;
	localparam int FLAG_HOT     = 1;
	localparam int FLAG_COLD    = 2;
	localparam int FLAG_SLOPE   = 3;
	localparam int FLAG_SHORT   = 4;

	// ---------------------------------------------------------------
	// Bay sequencer states
	// ---------------------------------------------------------------
	typedef enum logic [8:0] {
		ST_POLL       = 9'h001,
		ST_SOFT       = 9'h002,
		ST_FAST       = 9'h004,
		ST_TOP        = 9'h008,
		ST_MAINT      = 9'h010,
		ST_COLD_TOP   = 9'h020,
		ST_COLD_MAINT = 9'h040,
		ST_HOT        = 9'h080,
		ST_SHORT      = 9'h100
	} bay_state_t;

endpackage

// ==== verilog/battery_charge_sequencer.sv ====
`timescale 1ns/1ps
`default_nettype none

module battery_charge_sequencer
	import charge_seq_pkg::*;
#(
	parameter int NUM_BAYS    = 3,
	parameter int TICK_CYC    = charge_seq_pkg::TICK_CYCLES,
	parameter int SOFT_TICKS  = charge_seq_pkg::SOFT_START_TICKS,
	parameter int TOP_TICKS   = charge_seq_pkg::TOP_CHARGE_TICKS,
	parameter int FAST_TICKS  = charge_seq_pkg::FAST_LIMIT_TICKS,
	parameter int COLD_TICKS  = charge_seq_pkg::COLD_SAMPLE_TICKS,
	parameter int RAMP_TICKS  = charge_seq_pkg::RAMP_STEP_TICKS
) (
	input  wire logic                                      core_clk,
	input  wire logic                                      reset,
	input  wire logic                                      reset_button,
	input  wire logic [NUM_BAYS-1:0]                       bat_present,
	input  wire logic [NUM_BAYS-1:0]                       bat_hot,
	input  wire logic [NUM_BAYS-1:0]                       bat_cold,
	input  wire logic [NUM_BAYS-1:0]                       bat_neg_slope,
	input  wire logic [NUM_BAYS-1:0]                       bay_short,
	output wire logic [NUM_BAYS-1:0]                       red_led,
	output wire logic [NUM_BAYS-1:0]                       green_led,
	output wire logic [NUM_BAYS-1:0]                       yellow_led,
	output wire logic [NUM_BAYS-1:0]                       charge_en,
	output wire logic [NUM_BAYS-1:0]                       fwd_pulse,
	output wire logic [NUM_BAYS-1:0]                       rev_pulse,
	output wire logic [NUM_BAYS-1:0][charge_seq_pkg::LEVEL_W-1:0] current_level
);
	import charge_seq_pkg::*;

	localparam int TICK_W = $clog2(TICK_CYC + 1);

	// ---------------------------------------------------------------
	// Shared time base, blink phase, pulse pattern, button sync
	// ---------------------------------------------------------------
	logic [TICK_W-1:0]  tick_cnt_reg, tick_cnt_next;
	logic               tick_reg, tick_next;
	logic               blink_reg, blink_next;
	logic [PULSE_W-1:0] pulse_cnt_reg, pulse_cnt_next;
	logic               btn_s1_reg, btn_s2_reg;

	always_comb begin
		tick_cnt_next  = tick_cnt_reg + TICK_W'(1);
		tick_next      = 1'b0;
		blink_next     = blink_reg;
		pulse_cnt_next = pulse_cnt_reg + PULSE_W'(1);
		if (tick_cnt_reg == TICK_W'(TICK_CYC - 1)) begin
			tick_cnt_next = '0;
			tick_next     = 1'b1;
		end
		if (tick_reg) begin
			blink_next = ~blink_reg;
		end
		if (pulse_cnt_reg == PULSE_W'(PULSE_PERIOD_CYCLES - 1)) begin
			pulse_cnt_next = '0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			tick_cnt_reg  <= '0;
			tick_reg      <= 1'b0;
			blink_reg     <= 1'b0;
			pulse_cnt_reg <= '0;
			btn_s1_reg    <= 1'b0;
			btn_s2_reg    <= 1'b0;
		end else begin
			tick_cnt_reg  <= tick_cnt_next;
			tick_reg      <= tick_next;
			blink_reg     <= blink_next;
			pulse_cnt_reg <= pulse_cnt_next;
			btn_s1_reg    <= reset_button;
			btn_s2_reg    <= btn_s1_reg;
		end
	end

	// ---------------------------------------------------------------
	// One sequencer per bay
	// ---------------------------------------------------------------
	for (genvar b = 0; b < NUM_BAYS; b++) begin : g_bay
		logic [FLAG_W-1:0]  flag_s1_reg, flag_s2_reg;
		bay_state_t         state_reg, state_next;
		logic [CNT_W-1:0]   stage_cnt_reg, stage_cnt_next;
		logic [CNT_W-1:0]   fast_cnt_reg, fast_cnt_next;
		logic [CNT_W-1:0]   sub_cnt_reg, sub_cnt_next;
		logic [LEVEL_W-1:0] ramp_reg, ramp_next;
		logic               red_reg, red_next;
		logic               green_reg, green_next;
		logic               yellow_reg, yellow_next;
		logic               en_reg, en_next;
		logic               fwd_reg, fwd_next;
		logic               rev_reg, rev_next;
		logic [LEVEL_W-1:0] level_reg, level_next;
		logic               present, hot, cold, slope, shorted, charging;

		assign present = flag_s2_reg[FLAG_PRESENT];
		assign hot     = flag_s2_reg[FLAG_HOT];
		assign cold    = flag_s2_reg[FLAG_COLD];
		assign slope   = flag_s2_reg[FLAG_SLOPE];
		assign shorted = flag_s2_reg[FLAG_SHORT];
		assign charging = (state_reg != ST_POLL) && (state_reg != ST_HOT)
			&& (state_reg != ST_SHORT);

		always_comb begin
			state_next     = state_reg;
			stage_cnt_next = stage_cnt_reg;
			fast_cnt_next  = fast_cnt_reg;
			sub_cnt_next   = sub_cnt_reg;
			ramp_next      = ramp_reg;
			if (tick_reg) begin
				stage_cnt_next = stage_cnt_reg + CNT_W'(1);
				sub_cnt_next   = sub_cnt_reg + CNT_W'(1);
			end
			unique case (state_reg)
				ST_POLL: begin
					fast_cnt_next = '0;
					if (present) begin
						state_next     = ST_SOFT;
						stage_cnt_next = '0;
						sub_cnt_next   = '0;
						ramp_next      = LEVEL_OFF;
					end
				end
				ST_SOFT: begin
					if (tick_reg && sub_cnt_reg == CNT_W'(RAMP_TICKS - 1)) begin
						sub_cnt_next = '0;
						if (ramp_reg < LEVEL_FAST) begin
							ramp_next = ramp_reg + LEVEL_W'(1);
						end
					end
					if (tick_reg && stage_cnt_reg == CNT_W'(SOFT_TICKS - 1)) begin
						stage_cnt_next = '0;
						sub_cnt_next   = '0;
						state_next     = cold ? ST_COLD_TOP : ST_FAST;
					end
				end
				ST_FAST: begin
					if (tick_reg) begin
						fast_cnt_next = fast_cnt_reg + CNT_W'(1);
					end
					// Slope or timer; over-temperature is caught below
					if (slope || (tick_reg && fast_cnt_reg == CNT_W'(FAST_TICKS - 1))) begin
						state_next     = ST_TOP;
						stage_cnt_next = '0;
					end
				end
				ST_TOP: begin
					if (tick_reg && stage_cnt_reg == CNT_W'(TOP_TICKS - 1)) begin
						state_next = ST_MAINT;
					end
				end
				ST_MAINT: begin
					state_next = ST_MAINT;
				end
				ST_COLD_TOP, ST_COLD_MAINT: begin
					if (tick_reg && sub_cnt_reg == CNT_W'(COLD_TICKS - 1)) begin
						sub_cnt_next = '0;
						if (!cold) begin
							state_next = ST_FAST;
						end
					end
					if (state_reg == ST_COLD_TOP && state_next == ST_COLD_TOP
						&& tick_reg && stage_cnt_reg == CNT_W'(TOP_TICKS - 1)) begin
						state_next = cold ? ST_COLD_MAINT : ST_FAST;
					end
				end
				ST_HOT: begin
					state_next = ST_HOT;
				end
				ST_SHORT: begin
					if (!shorted) begin
						state_next = ST_POLL;
					end
				end
			endcase
			// Overrides, highest first
			if (btn_s2_reg) begin
				state_next    = ST_POLL;
				fast_cnt_next = '0;
			end else if (!present && state_reg != ST_HOT) begin
				state_next    = ST_POLL;
				fast_cnt_next = '0;
			end else if (hot && charging) begin
				state_next = ST_HOT;
			end else if (shorted && state_reg != ST_HOT) begin
				state_next = ST_SHORT;
			end
		end

		// Indicator and drive outputs follow the next state so they stay registered
		always_comb begin
			red_next    = 1'b0;
			green_next  = 1'b0;
			yellow_next = 1'b0;
			level_next  = LEVEL_OFF;
			unique case (state_next)
				ST_POLL: begin
					yellow_next = blink_next;
				end
				ST_SOFT: begin
					red_next   = 1'b1;
					level_next = ramp_next;
				end
				ST_FAST: begin
					red_next   = 1'b1;
					level_next = LEVEL_FAST;
				end
				ST_TOP: begin
					green_next = 1'b1;
					level_next = LEVEL_TOP;
				end
				ST_MAINT: begin
					green_next = 1'b1;
					level_next = LEVEL_MAINT;
				end
				ST_COLD_TOP: begin
					green_next  = 1'b1;
					yellow_next = 1'b1;
					level_next  = LEVEL_TOP;
				end
				ST_COLD_MAINT: begin
					green_next  = 1'b1;
					yellow_next = 1'b1;
					level_next  = LEVEL_MAINT;
				end
				ST_HOT: begin
					yellow_next = 1'b1;
				end
				ST_SHORT: begin
					green_next  = blink_next;
					yellow_next = 1'b1;
				end
			endcase
			en_next  = (level_next != LEVEL_OFF);
			// Reverse pulse kept short so net charge stays positive
			fwd_next = en_next && (pulse_cnt_next < PULSE_W'(FWD_END_CYCLES));
			rev_next = en_next && (pulse_cnt_next >= PULSE_W'(REV_START_CYCLES))
				&& (pulse_cnt_next < PULSE_W'(REV_END_CYCLES));
		end

		always_ff @(posedge core_clk) begin
			if (reset) begin
				flag_s1_reg   <= '0;
				flag_s2_reg   <= '0;
				state_reg     <= ST_POLL;
				stage_cnt_reg <= '0;
				fast_cnt_reg  <= '0;
				sub_cnt_reg   <= '0;
				ramp_reg      <= LEVEL_OFF;
				red_reg       <= 1'b0;
				green_reg     <= 1'b0;
				yellow_reg    <= 1'b0;
				en_reg        <= 1'b0;
				fwd_reg       <= 1'b0;
				rev_reg       <= 1'b0;
				level_reg     <= LEVEL_OFF;
			end else begin
				flag_s1_reg   <= {bay_short[b], bat_neg_slope[b], bat_cold[b],
					bat_hot[b], bat_present[b]};
				flag_s2_reg   <= flag_s1_reg;
				state_reg     <= state_next;
				stage_cnt_reg <= stage_cnt_next;
				fast_cnt_reg  <= fast_cnt_next;
				sub_cnt_reg   <= sub_cnt_next;
				ramp_reg      <= ramp_next;
				red_reg       <= red_next;
				green_reg     <= green_next;
				yellow_reg    <= yellow_next;
				en_reg        <= en_next;
				fwd_reg       <= fwd_next;
				rev_reg       <= rev_next;
				level_reg     <= level_next;
			end
		end

		assign red_led[b]       = red_reg;
		assign green_led[b]     = green_reg;
		assign yellow_led[b]    = yellow_reg;
		assign charge_en[b]     = en_reg;
		assign fwd_pulse[b]     = fwd_reg;
		assign rev_pulse[b]     = rev_reg;
		assign current_level[b] = level_reg;
	end

endmodule

`default_nettype wire

// ==== tb/battery_charge_sequencer_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Port checker
// ----------------------------------------
module charge_seq_checker
	import charge_seq_pkg::*;
#(
	parameter int NUM_BAYS = 3
) (
	input wire logic                              core_clk,
	input wire logic                              reset,
	input wire logic                              reset_button,
	input wire logic [NUM_BAYS-1:0]               bat_present,
	input wire logic [NUM_BAYS-1:0]               bat_hot,
	input wire logic [NUM_BAYS-1:0]               bat_neg_slope,
	input wire logic [NUM_BAYS-1:0]               bay_short,
	input wire logic [NUM_BAYS-1:0]               red_led,
	input wire logic [NUM_BAYS-1:0]               green_led,
	input wire logic [NUM_BAYS-1:0]               yellow_led,
	input wire logic [NUM_BAYS-1:0]               charge_en,
	input wire logic [NUM_BAYS-1:0]               fwd_pulse,
	input wire logic [NUM_BAYS-1:0]               rev_pulse,
	input wire logic [NUM_BAYS-1:0][LEVEL_W-1:0]  current_level
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);

	property p_status_excl; !(|(red_led & green_led)); endproperty
	a_status_excl: assert property (p_status_excl) else $error("red and green together");
	property p_red_no_yellow; !(|(red_led & yellow_led)); endproperty
	a_red_no_yellow: assert property (p_red_no_yellow) else $error("red with yellow");
	property p_dark_no_current; !(|(charge_en & ~red_led & ~green_led)); endproperty
	a_dark_no_current: assert property (p_dark_no_current) else $error("current while dark");
	// Pulse flops and enable flop load in the same cycle
	property p_pulse_needs_en;
		!(|((fwd_pulse | rev_pulse) & ~charge_en));
	endproperty
	a_pulse_needs_en: assert property (p_pulse_needs_en) else $error("pulse without enable");
	property p_insert_red;
		$rose(bat_present[0]) && !red_led[0] && !green_led[0] && !bat_hot[0] && !bay_short[0]
			&& !reset_button |-> ##[2:4] red_led[0];
	endproperty
	a_insert_red: assert property (p_insert_red) else $error("no soft start on insert");
	property p_hot_cut;
		$rose(bat_hot[0]) && red_led[0] && bat_present[0] && !bay_short[0] && !reset_button
			|-> ##[2:4] (yellow_led[0] && !red_led[0] && !charge_en[0]);
	endproperty
	a_hot_cut: assert property (p_hot_cut) else $error("no hot shutdown");
	property p_green_rate;
		green_led[0] && !yellow_led[0]
			|-> current_level[0] == LEVEL_TOP || current_level[0] == LEVEL_MAINT;
	endproperty
	a_green_rate: assert property (p_green_rate) else $error("wrong reduced rate");
	property p_slope_end;
		red_led[0] && current_level[0] == LEVEL_FAST && bat_neg_slope[0] && bat_present[0]
			&& !bat_hot[0] && !bay_short[0] && !reset_button |-> ##[1:4] green_led[0];
	endproperty
	a_slope_end: assert property (p_slope_end) else $error("slope did not end fast");
endmodule

bind battery_charge_sequencer charge_seq_checker #(.NUM_BAYS(NUM_BAYS)) chk_u (
	.core_clk, .reset, .reset_button, .bat_present, .bat_hot, .bat_neg_slope, .bay_short,
	.red_led, .green_led, .yellow_led, .charge_en, .fwd_pulse, .rev_pulse, .current_level
);
`default_nettype wire

// ==== tb/battery_pack_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Battery pack sensors and push-button
// ----------------------------------------
module battery_pack_model
	import charge_seq_pkg::*;
(
	input  wire logic        core_clk,
	output var  logic        reset_button,
	output var  logic [2:0]  bat_present,
	output var  logic [2:0]  bat_hot,
	output var  logic [2:0]  bat_cold,
	output var  logic [2:0]  bat_neg_slope,
	output var  logic [2:0]  bay_short
);
	initial begin
		{reset_button, bat_present, bat_hot, bat_cold, bat_neg_slope, bay_short} = '0;
	end
	// Pins change on the falling edge, clear of the sampling edge
	task automatic set_flag(input int f, input int b, input logic v);
		@(negedge core_clk);
		case (f)
			FLAG_PRESENT: bat_present[b] = v;
			FLAG_HOT: bat_hot[b] = v;
			FLAG_COLD: bat_cold[b] = v;
			FLAG_SLOPE: bat_neg_slope[b] = v;
			default: bay_short[b] = v;
		endcase
	endtask
	task automatic press_button(input int n);
		@(negedge core_clk);
		reset_button = 1'b1;
		repeat (n) @(negedge core_clk);
		reset_button = 1'b0;
	endtask
endmodule
`default_nettype wire

// ==== tb/test_battery_charge_sequencer.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Bay sequencer bench, bay 0 exercised
// ----------------------------------------
module test_battery_charge_sequencer;
	import charge_seq_pkg::*;
	localparam int TK = 4, SOFT = 8, TOP = 10, FAST = 12, COLD = 2;
	logic            core_clk, reset, reset_button;
	logic [2:0]      bat_present, bat_hot, bat_cold, bat_neg_slope, bay_short;
	logic [2:0]      red_led, green_led, yellow_led, charge_en, fwd_pulse, rev_pulse;
	logic [2:0][7:0] current_level;
	int              n_errors = 0, check_count = 0, el, nt, nf, nr;

	battery_charge_sequencer #(.TICK_CYC(TK), .SOFT_TICKS(SOFT), .TOP_TICKS(TOP),
		.FAST_TICKS(FAST), .COLD_TICKS(COLD), .RAMP_TICKS(1)) dut_u (
		.core_clk, .reset, .reset_button, .bat_present, .bat_hot, .bat_cold, .bat_neg_slope,
		.bay_short, .red_led, .green_led, .yellow_led, .charge_en, .fwd_pulse, .rev_pulse,
		.current_level
	);
	battery_pack_model pack_u (.core_clk, .reset_button, .bat_present, .bat_hot, .bat_cold,
		.bat_neg_slope, .bay_short);

	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	task automatic report_and_stop;
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk_bit(input string nm, input logic e, input logic g);
		check_count++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %s: expected %b seen %b", nm, e, g);
		end
	endtask
	task automatic chk_num(input string nm, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask
	// Bounded wait for bay 0 to show red, green and level
	task automatic wait_bay(input logic r, input logic g, input logic [7:0] lv, input int lim);
		el = 0;
		while (!(red_led[0] === r && green_led[0] === g && current_level[0] === lv)) begin
			@(negedge core_clk);
			el++;
			if (el > lim) begin
				n_errors++;
				$display("unexpected bay state: expected %b%b %h seen %b%b %h", r, g, lv,
					red_led[0], green_led[0], current_level[0]);
				report_and_stop;
			end
		end
	endtask
	// Any 32-cycle window holds exactly eight ticks, whatever the phase
	task automatic count_flips(input logic sel, input int n);
		logic p;
		nt = 0;
		p = sel ? green_led[0] : yellow_led[0];
		repeat (n) begin
			@(negedge core_clk);
			if ((sel ? green_led[0] : yellow_led[0]) !== p)
				nt++;
			p = sel ? green_led[0] : yellow_led[0];
		end
	endtask

	initial begin
		reset = 1'b1;
		repeat (2) @(negedge core_clk);
		reset = 1'b0;
		repeat (3) @(negedge core_clk);
		chk_bit("poll red", 1'b0, red_led[0]);
		count_flips(1'b0, 8 * TK);
		chk_num("poll flips", 16'd8, 16'(nt));
		pack_u.set_flag(FLAG_PRESENT, 0, 1'b1);
		wait_bay(1'b1, 1'b0, LEVEL_FAST, SOFT * TK + 12);
		chk_bit("soft length", 1'b1, el >= (SOFT - 1) * TK);
		chk_bit("yellow stopped", 1'b0, yellow_led[0]);
		chk_num("idle bays", 16'h0,
			16'({red_led[2:1], green_led[2:1], charge_en[2:1]}));
		// Fast stage lasts only FAST ticks here, so look while it stands
		repeat (8) @(negedge core_clk);
		chk_num("fast held", 16'(LEVEL_FAST), 16'(current_level[0]));
		pack_u.set_flag(FLAG_SLOPE, 0, 1'b1);
		wait_bay(1'b0, 1'b1, LEVEL_TOP, 6);
		pack_u.set_flag(FLAG_SLOPE, 0, 1'b0);
		wait_bay(1'b0, 1'b1, LEVEL_MAINT, TOP * TK + 8);
		chk_bit("topping length", 1'b1, el >= (TOP - 1) * TK);
		repeat (40) @(negedge core_clk);
		chk_num("maint held", 16'(LEVEL_MAINT), 16'(current_level[0]));
		nf = 0;
		nr = 0;
		repeat (PULSE_PERIOD_CYCLES) begin
			@(negedge core_clk);
			nf += fwd_pulse[0];
			nr += rev_pulse[0];
		end
		chk_num("fwd cycles", 16'(FWD_END_CYCLES), 16'(nf));
		chk_num("rev cycles", 16'(REV_END_CYCLES - REV_START_CYCLES), 16'(nr));
		repeat (2) begin
			pack_u.set_flag(FLAG_PRESENT, 0, 1'b0);
			wait_bay(1'b0, 1'b0, LEVEL_OFF, 6);
			pack_u.set_flag(FLAG_PRESENT, 0, 1'b1);
			wait_bay(1'b1, 1'b0, 8'h04, SOFT * TK);
			wait_bay(1'b1, 1'b0, LEVEL_FAST, SOFT * TK + 12);
			wait_bay(1'b0, 1'b1, LEVEL_TOP, FAST * TK + 8);
			chk_bit("fast timer cleared", 1'b1, el >= (FAST - 1) * TK);
		end
		pack_u.set_flag(FLAG_PRESENT, 0, 1'b0);
		pack_u.set_flag(FLAG_PRESENT, 0, 1'b1);
		wait_bay(1'b1, 1'b0, LEVEL_FAST, SOFT * TK + 12);
		pack_u.set_flag(FLAG_HOT, 0, 1'b1);
		wait_bay(1'b0, 1'b0, LEVEL_OFF, 6);
		pack_u.set_flag(FLAG_PRESENT, 0, 1'b0);
		pack_u.set_flag(FLAG_HOT, 0, 1'b0);
		count_flips(1'b0, 8 * TK);
		chk_num("hot latch flips", 16'h0, 16'(nt));
		chk_bit("hot yellow", 1'b1, yellow_led[0]);
		pack_u.press_button(3);
		repeat (4) @(negedge core_clk);
		count_flips(1'b0, 8 * TK);
		chk_num("poll after button", 16'd8, 16'(nt));
		pack_u.set_flag(FLAG_COLD, 0, 1'b1);
		pack_u.set_flag(FLAG_PRESENT, 0, 1'b1);
		wait_bay(1'b0, 1'b1, LEVEL_TOP, SOFT * TK + 12);
		chk_bit("cold yellow", 1'b1, yellow_led[0]);
		wait_bay(1'b0, 1'b1, LEVEL_MAINT, TOP * TK + 8);
		chk_bit("cold maint yellow", 1'b1, yellow_led[0]);
		pack_u.set_flag(FLAG_COLD, 0, 1'b0);
		wait_bay(1'b1, 1'b0, LEVEL_FAST, COLD * TK + 8);
		pack_u.set_flag(FLAG_SHORT, 0, 1'b1);
		repeat (6) @(negedge core_clk);
		chk_bit("short yellow", 1'b1, yellow_led[0]);
		chk_bit("short current", 1'b0, charge_en[0]);
		count_flips(1'b1, 8 * TK);
		chk_num("short green flips", 16'd8, 16'(nt));
		pack_u.set_flag(FLAG_SHORT, 0, 1'b0);
		pack_u.set_flag(FLAG_PRESENT, 0, 1'b0);
		wait_bay(1'b0, 1'b0, LEVEL_OFF, 8);
		repeat (6) @(negedge core_clk);
		chk_bit("open no current", 1'b0, charge_en[0]);
		report_and_stop;
	end
endmodule
`default_nettype wire
